// >>> verilog/pcs_defs.svh
// timing counts and encodings for the pc card strobe sequencer
`ifndef PCS_DEFS_SVH
`define PCS_DEFS_SVH

`define PCS_CLK_HZ        20000000
`define PCS_SETUP_NS      70
`define PCS_STROBE_NS     170
`define PCS_HOLD_NS       30
// least times round up to whole cycles
`define PCS_CYC(ns) ((((ns) * (`PCS_CLK_HZ / 1000000)) + 999) / 1000)
`define PCS_SETUP_CYC     `PCS_CYC(`PCS_SETUP_NS)
`define PCS_STROBE_CYC    `PCS_CYC(`PCS_STROBE_NS)
`define PCS_HOLD_CYC      `PCS_CYC(`PCS_HOLD_NS)
`define PCS_CNT_W         4
`define PCS_ACT           1'b0
`define PCS_IDLE          1'b1
`define PCS_LANE_EVEN     2'b01
`define PCS_LANE_ODD      2'b10

`endif

// >>> verilog/pcs_pkg.sv
// types for the pc card strobe sequencer
package pcs_pkg;

  typedef enum logic [1:0] {
    PCS_IO_RD  = 2'h0,
    PCS_IO_WR  = 2'h1,
    PCS_DMA_RD = 2'h2,
    PCS_DMA_WR = 2'h3
  } pcs_kind_t;

  typedef struct packed {
    pcs_kind_t  kind;
    logic [1:0] lanes;
  } pcs_req_t;

  typedef struct packed {
    logic ce1_n;
    logic ce2_n;
    logic iord_n;
    logic iowr_n;
    logic reg_n;
  } pcs_pins_t;

  typedef enum logic [3:0] {
    PCS_ST_IDLE   = 4'b0001,
    PCS_ST_SETUP  = 4'b0010,
    PCS_ST_STROBE = 4'b0100,
    PCS_ST_HOLD   = 4'b1000
  } pcs_state_t;

endpackage : pcs_pkg

// >>> verilog/pcs_strobe_ctrl.sv
// card enable and i/o strobe sequencer for one 16-bit pc card socket
`include "pcs_defs.svh"

module pcs_strobe_ctrl (
  input  wire logic              i_ref_clk,
  input  wire logic              i_resetn,
  input  wire logic              i_req_valid,
  input  wire pcs_pkg::pcs_req_t i_req,
  input  wire logic              i_inpack_n,
  input  wire logic              i_wait_n,
  output logic                   o_req_ready,
  output logic                   o_done,
  output logic                   o_inpack_seen,
  output logic                   o_dma_req,
  output pcs_pkg::pcs_pins_t     o_pins
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic is_read(input pcs_pkg::pcs_kind_t k);
    return (k == pcs_pkg::PCS_IO_RD) || (k == pcs_pkg::PCS_DMA_RD);
  endfunction : is_read

  function automatic logic is_dma(input pcs_pkg::pcs_kind_t k);
    return (k == pcs_pkg::PCS_DMA_RD) || (k == pcs_pkg::PCS_DMA_WR);
  endfunction : is_dma

  // ----------------------------------------------------------------
  // pin synchronisers: three flops, change taken when 2nd and 3rd agree
  // ----------------------------------------------------------------
  logic [2:0] inpack_sync_ff;
  logic [2:0] wait_sync_ff;
  logic       inpack_n_ff;
  logic       wait_n_ff;

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      inpack_sync_ff <= {3{`PCS_IDLE}};
    end else begin
      inpack_sync_ff <= {inpack_sync_ff[1:0], i_inpack_n};
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      wait_sync_ff <= {3{`PCS_IDLE}};
    end else begin
      wait_sync_ff <= {wait_sync_ff[1:0], i_wait_n};
    end
  end

  // one disagreeing sample is a glitch or a settling flop
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      inpack_n_ff <= `PCS_IDLE;
    end else if (inpack_sync_ff[1] == inpack_sync_ff[2]) begin
      inpack_n_ff <= inpack_sync_ff[2];
    end
  end

  // filtered wait trails the pin by four clocks, so a card must
  // pull it low while still in setup to stretch the strobe
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      wait_n_ff <= `PCS_IDLE;
    end else if (wait_sync_ff[1] == wait_sync_ff[2]) begin
      wait_n_ff <= wait_sync_ff[2];
    end
  end

  // ----------------------------------------------------------------
  // cycle sequencer
  // ----------------------------------------------------------------
  pcs_pkg::pcs_state_t       state_ff;
  pcs_pkg::pcs_state_t       nxt_state;
  pcs_pkg::pcs_req_t         req_ff;
  logic [`PCS_CNT_W-1:0]     cnt_ff;
  logic [`PCS_CNT_W-1:0]     nxt_cnt;
  logic                      cnt_zero;

  assign cnt_zero = (cnt_ff == `PCS_CNT_W'(0));

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    unique case (state_ff)
      pcs_pkg::PCS_ST_IDLE: begin
        // an empty lane mask would give no card enable, so it is dropped
        if (i_req_valid && (i_req.lanes != 2'h0)) begin
          nxt_state = pcs_pkg::PCS_ST_SETUP;
          nxt_cnt   = `PCS_CNT_W'(`PCS_SETUP_CYC - 1);
        end
      end
      pcs_pkg::PCS_ST_SETUP: begin
        if (cnt_zero) begin
          nxt_state = pcs_pkg::PCS_ST_STROBE;
          nxt_cnt   = `PCS_CNT_W'(`PCS_STROBE_CYC - 1);
        end else begin
          nxt_cnt = cnt_ff - `PCS_CNT_W'(1);
        end
      end
      pcs_pkg::PCS_ST_STROBE: begin
        // card wait stretches the strobe past its minimum width
        if (cnt_zero && wait_n_ff) begin
          nxt_state = pcs_pkg::PCS_ST_HOLD;
          nxt_cnt   = `PCS_CNT_W'(`PCS_HOLD_CYC - 1);
        end else if (!cnt_zero) begin
          nxt_cnt = cnt_ff - `PCS_CNT_W'(1);
        end
      end
      pcs_pkg::PCS_ST_HOLD: begin
        if (cnt_zero) begin
          nxt_state = pcs_pkg::PCS_ST_IDLE;
        end else begin
          nxt_cnt = cnt_ff - `PCS_CNT_W'(1);
        end
      end
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      state_ff <= pcs_pkg::PCS_ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      cnt_ff <= `PCS_CNT_W'(0);
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      req_ff <= '0;
    end else if ((state_ff == pcs_pkg::PCS_ST_IDLE) &&
                 (nxt_state == pcs_pkg::PCS_ST_SETUP)) begin
      req_ff <= i_req;
    end
  end

  // ----------------------------------------------------------------
  // socket pins, registered so every output is a flop
  // ----------------------------------------------------------------
  logic in_cycle;
  logic in_strobe;

  assign in_cycle  = (nxt_state != pcs_pkg::PCS_ST_IDLE);
  assign in_strobe = (nxt_state == pcs_pkg::PCS_ST_STROBE);

  pcs_pkg::pcs_req_t cur_req;
  assign cur_req = (state_ff == pcs_pkg::PCS_ST_IDLE) ? i_req : req_ff;

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      o_pins <= '{`PCS_IDLE, `PCS_IDLE, `PCS_IDLE, `PCS_IDLE, `PCS_IDLE};
    end else begin
      o_pins.ce1_n <= (in_cycle && cur_req.lanes[0]) ? `PCS_ACT
                                                      : `PCS_IDLE;
      o_pins.ce2_n <= (in_cycle && cur_req.lanes[1]) ? `PCS_ACT
                                                      : `PCS_IDLE;
      // one strobe chosen from one kind, so both can never be low
      o_pins.iord_n <= (in_strobe && is_read(cur_req.kind))
                       ? `PCS_ACT : `PCS_IDLE;
      o_pins.iowr_n <= (in_strobe && !is_read(cur_req.kind))
                       ? `PCS_ACT : `PCS_IDLE;
      // reg covers the whole dma cycle and so frames the strobe
      o_pins.reg_n <= (in_cycle && is_dma(cur_req.kind))
                      ? `PCS_ACT : `PCS_IDLE;
    end
  end

  // ----------------------------------------------------------------
  // user side status
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      o_req_ready <= 1'b0;
      o_done      <= 1'b0;
    end else begin
      o_req_ready <= (nxt_state == pcs_pkg::PCS_ST_IDLE);
      o_done      <= (state_ff == pcs_pkg::PCS_ST_HOLD) && cnt_zero;
    end
  end

  // acknowledge only counts during an io read strobe
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      o_inpack_seen <= 1'b0;
    end else begin
      o_inpack_seen <= (state_ff == pcs_pkg::PCS_ST_STROBE) &&
                       (req_ff.kind == pcs_pkg::PCS_IO_RD) &&
                       !inpack_n_ff;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      o_dma_req <= 1'b0;
    end else begin
      o_dma_req <= !inpack_n_ff;
    end
  end

endmodule : pcs_strobe_ctrl

// >>> tb/pcs_strobe_ctrl_assertions.sv
// port assertions for the strobe sequencer
module pcs_chk (
  input wire logic               i_ref_clk,
  input wire logic               i_resetn,
  input wire logic               i_req_valid,
  input wire pcs_pkg::pcs_req_t  i_req,
  input wire logic               i_inpack_n,
  input wire logic               o_req_ready,
  input wire logic               o_done,
  input wire logic               o_dma_req,
  input wire pcs_pkg::pcs_pins_t o_pins
);
  timeunit 1ns;
  timeprecision 1ns;
  // --------
  // checks
  // --------
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);
  wire tk = i_req_valid && o_req_ready && (i_req.lanes != 2'h0);
  wire st = !(o_pins.iord_n && o_pins.iowr_n);
  even_lane_a: assert property (
    tk |=> o_pins.ce1_n == !$past(i_req.lanes[0])) else $error("ce1 bad");
  odd_lane_a: assert property (
    tk |=> o_pins.ce2_n == !$past(i_req.lanes[1])) else $error("ce2 bad");
  rd_strobe_a: assert property (
    tk && !i_req.kind[0] |-> ##3 !o_pins.iord_n) else $error("no iord");
  wr_strobe_a: assert property (
    tk && i_req.kind[0] |-> ##3 !o_pins.iowr_n) else $error("no iowr");
  rd_width_a: assert property (
    $fell(o_pins.iord_n) |-> !o_pins.iord_n [*4]) else $error("iord short");
  dma_ack_a: assert property (
    tk && i_req.kind[1] |=> !o_pins.reg_n ##2 st && !o_pins.reg_n)
    else $error("reg bad");
  no_overlap_a: assert property (
    o_pins.iord_n || o_pins.iowr_n) else $error("both strobes");
  idle_high_a: assert property (
    o_req_ready |-> o_pins == 5'h1f) else $error("idle pins low");
  cycle_end_a: assert property (
    tk |-> ##[8:40] o_done) else $error("no done");
  dma_req_a: assert property (
    !i_inpack_n [*8] |-> o_dma_req) else $error("no dma req");
  cover property (tk && i_req.kind[1]);
  cover property ($fell(o_pins.iowr_n));
  cover property (o_dma_req);
endmodule : pcs_chk

// >>> tb/pcs_card_model.sv
// card model facing the strobe sequencer
module pcs_card (
  input  wire pcs_pkg::pcs_pins_t i_pins,
  input  wire logic               i_ack_en,
  input  wire logic               i_dma_rq,
  input  wire logic               i_stall,
  output logic                    o_inpack_n,
  output logic                    o_wait_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // decodes as soon as a lane is enabled in an io cycle; pulled up when idle unless i_dma_rq is high
  assign o_inpack_n = !(i_ack_en && i_pins.reg_n
    && !(i_pins.ce1_n && i_pins.ce2_n)) && !i_dma_rq;
  // wait is pulled while enabled so the slow pin filter still sees it
  assign o_wait_n = !(i_stall && !(i_pins.ce1_n && i_pins.ce2_n));
endmodule : pcs_card

// >>> tb/pc_card_16bit_io_strobes_bench.sv
// self-checking bench for the strobe sequencer
module pc_card_16bit_io_strobes_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_n, vld, ack_en, dma_rq, stall;
  logic inp_n, wait_n, rdy, done, seen, dreq;
  pcs_pkg::pcs_req_t  req;
  pcs_pkg::pcs_pins_t pins;
  int error_cnt = 0;
  int compares = 0;
  pcs_strobe_ctrl u_dut (.i_ref_clk(clk), .i_resetn(rst_n),
    .i_req_valid(vld), .i_req(req), .i_inpack_n(inp_n),
    .i_wait_n(wait_n), .o_req_ready(rdy), .o_done(done),
    .o_inpack_seen(seen), .o_dma_req(dreq), .o_pins(pins));
  pcs_card u_card (.i_pins(pins), .i_ack_en(ack_en),
    .i_dma_rq(dma_rq), .i_stall(stall), .o_inpack_n(inp_n),
    .o_wait_n(wait_n));
  // --------
  // tasks
  // --------
  task automatic end_sim;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // lo gathers any pin that went low during the cycle
  task automatic xfer(input logic [3:0] r, output int n,
                      output logic [4:0] lo, output logic sn);
    lo = 5'h1f;
    sn = 1'b0;
    n = 0;
    @(posedge clk);
    vld <= 1'b1;
    req <= r;
    @(posedge clk);
    vld <= 1'b0;
    while (done !== 1'b1) begin
      @(negedge clk);
      lo = lo & pins;
      sn = sn | seen;
      n++;
      if (n > 60) begin
        error_cnt++;
        end_sim();
      end
    end
  endtask : xfer
  task automatic t_kinds;
    int n;
    logic [4:0] lo;
    logic sn;
    for (int k = 0; k < 4; k++) begin
      for (int l = 1; l < 4; l++) begin
        xfer({k[1:0], l[1:0]}, n, lo, sn);
        chk(8'(lo), 8'({!l[0], !l[1], k[0], !k[0], !k[1]}));
        chk(8'(n), 8'h08);
      end
    end
  endtask : t_kinds
  task automatic t_stall;
    int n;
    logic [4:0] lo;
    logic sn;
    @(posedge clk);
    stall <= 1'b1;
    fork
      xfer(4'h5, n, lo, sn);
      begin
        repeat (12) @(posedge clk);
        stall <= 1'b0;
      end
    join
    chk(8'(n), 8'h11);
    chk(8'(lo), 8'h0d);
  endtask : t_stall
  task automatic t_inpack;
    int n;
    logic [4:0] lo;
    logic sn;
    @(posedge clk);
    ack_en <= 1'b1;
    xfer(4'h3, n, lo, sn);
    chk(8'(sn), 8'h01);
    xfer(4'h7, n, lo, sn);
    chk(8'(sn), 8'h00);
    @(posedge clk);
    ack_en <= 1'b0;
  endtask : t_inpack
  task automatic t_refuse;
    @(posedge clk);
    vld <= 1'b1;
    req <= 4'h0;
    repeat (10) @(negedge clk);
    chk(8'({rdy, pins}), 8'h3f);
    @(posedge clk);
    vld <= 1'b0;
  endtask : t_refuse
  task automatic t_dreq;
    @(posedge clk);
    dma_rq <= 1'b1;
    repeat (10) @(negedge clk);
    chk(8'(dreq), 8'h01);
    @(posedge clk);
    dma_rq <= 1'b0;
    repeat (10) @(negedge clk);
    chk(8'(dreq), 8'h00);
  endtask : t_dreq
  // --------
  // main
  // --------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    {rst_n, vld, ack_en, dma_rq, stall} = 5'h00;
    req = 4'h0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    t_kinds();
    t_stall();
    t_inpack();
    t_refuse();
    t_dreq();
    end_sim();
  end
endmodule : pc_card_16bit_io_strobes_bench
bind pcs_strobe_ctrl pcs_chk u_chk (.i_ref_clk, .i_resetn, .i_req_valid,
  .i_req, .i_inpack_n, .o_req_ready, .o_done, .o_dma_req, .o_pins);
